// ### pkg/mem_decode_map.svh
`ifndef MEM_DECODE_MAP_SVH
`define MEM_DECODE_MAP_SVH
`define PC_WIDTH 13
`define INSN_WIDTH 14
`define PROG_IMPL_WIDTH 10
`define PROG_IMPL_LAST 13'h03FF
`define RESET_VECTOR 13'h0000
`define IRQ_VECTOR 13'h0004
`define DATA_WIDTH 8
`define OPERAND_WIDTH 7
`define DADDR_WIDTH 8
`define SFR_LAST 7'h1F
`define GPR_FIRST 7'h20
`define GPR_LAST 7'h5F
`define GPR_DEPTH 64
`define GPR_IDX_WIDTH 6
`define BANK_BIT_POS 5
`define STATUS_RESET 8'h18
`endif

// ### pkg/mem_decode_pkg.sv
package mem_decode_pkg;
	typedef enum logic [1:0] {
		REGION_SFR = 2'b00,
		REGION_GPR = 2'b01,
		REGION_NONE = 2'b10
	} region_t;

	typedef struct packed {
		logic valid;
		logic indirect;
		logic [6:0] operand;
		logic [7:0] pointer;
		logic wr;
		logic [7:0] wdata;
	} data_req_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [1:0] region;
	} data_dec_t;
endpackage : mem_decode_pkg

// ### rtl/gpr_ram.sv
`timescale 1ns/10ps
`include "mem_decode_map.svh"
module gpr_ram (
	input wire logic clk_sys_i,
	input wire logic we_i,
	input wire logic [`GPR_IDX_WIDTH-1:0] idx_i,
	input wire logic [`DATA_WIDTH-1:0] wdata_i,
	output logic [`DATA_WIDTH-1:0] rdata_o
);
	logic [`DATA_WIDTH-1:0] mem [0:`GPR_DEPTH-1];

	always_ff @(posedge clk_sys_i) begin
		if (we_i) begin
			mem[idx_i] <= wdata_i;
		end
	end

	always_comb begin
		rdata_o = mem[idx_i];
	end
endmodule : gpr_ram

// ### rtl/memory_map_bank_decoder.sv
`timescale 1ns/10ps
`include "mem_decode_map.svh"
module memory_map_bank_decoder (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic pc_load_i,
	input wire logic [`PC_WIDTH-1:0] pc_load_val_i,
	input wire logic pc_inc_i,
	input wire logic irq_take_i,
	input wire logic status_wr_i,
	input wire logic [`DATA_WIDTH-1:0] status_wdata_i,
	input wire mem_decode_pkg::data_req_t req_i,
	input wire logic [`DATA_WIDTH-1:0] sfr_rdata_i,
	output logic [`PC_WIDTH-1:0] pc_o,
	output logic [`PROG_IMPL_WIDTH-1:0] prog_addr_o,
	output logic [`DATA_WIDTH-1:0] status_o,
	output logic sfr_sel_o,
	output logic [`DATA_WIDTH-1:0] sfr_addr_o,
	output logic [`DATA_WIDTH-1:0] rdata_o,
	output logic rvalid_o
);
	import mem_decode_pkg::*;

	logic [`PC_WIDTH-1:0] pc_r;
	logic [`DATA_WIDTH-1:0] status_r;
	logic [`DATA_WIDTH-1:0] rdata_r;
	logic rvalid_r;
	logic sfr_sel_r;
	logic [`DATA_WIDTH-1:0] sfr_addr_r;
	logic region_sfr_r;
	logic [`DATA_WIDTH-1:0] ram_rdata;
	logic ram_we;
	data_dec_t dec;

	function automatic logic [1:0] classify(input logic [6:0] low);
		if (low <= `SFR_LAST) begin
			classify = REGION_SFR;
		end else if (low >= `GPR_FIRST && low <= `GPR_LAST) begin
			classify = REGION_GPR;
		end else begin
			classify = REGION_NONE;
		end
	endfunction : classify

	always_comb begin
		dec.addr = req_i.pointer;
		if (!req_i.indirect) begin
			dec.addr = {status_r[`BANK_BIT_POS], req_i.operand};
		end
		dec.region = classify(dec.addr[6:0]);
	end

	assign ram_we = req_i.valid && req_i.wr && (dec.region == REGION_GPR);

	gpr_ram u_gpr (
		.clk_sys_i(clk_sys_i),
		.we_i(ram_we),
		.idx_i(`GPR_IDX_WIDTH'(dec.addr[6:0] - `GPR_FIRST)),
		.wdata_i(req_i.wdata),
		.rdata_o(ram_rdata)
	);

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			pc_r <= `RESET_VECTOR;
		end else if (irq_take_i) begin
			pc_r <= `IRQ_VECTOR;
		end else if (pc_load_i) begin
			pc_r <= pc_load_val_i;
		end else if (pc_inc_i) begin
			pc_r <= pc_r + `PC_WIDTH'(1);
		end
	end

	assign pc_o = pc_r;
	assign prog_addr_o = pc_r[`PROG_IMPL_WIDTH-1:0];

	// Status register; bits 7:6 forced to zero as reserved
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			status_r <= `STATUS_RESET;
		end else if (status_wr_i) begin
			status_r <= {2'b00, status_wdata_i[5:0]};
		end
	end

	assign status_o = status_r;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			sfr_sel_r <= 1'b0;
			sfr_addr_r <= 8'h00;
			region_sfr_r <= 1'b0;
			rvalid_r <= 1'b0;
		end else begin
			sfr_sel_r <= req_i.valid && (dec.region == REGION_SFR);
			sfr_addr_r <= dec.addr;
			region_sfr_r <= dec.region == REGION_SFR;
			rvalid_r <= req_i.valid && !req_i.wr;
		end
	end

	assign sfr_sel_o = sfr_sel_r;
	assign sfr_addr_o = sfr_addr_r;
	assign rvalid_o = rvalid_r;

	// RAM and unimplemented read data registered one cycle after request; special register reads bypass this register
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rdata_r <= 8'h00;
		end else if (req_i.valid && !req_i.wr) begin
			case (dec.region)
				REGION_GPR: rdata_r <= ram_rdata;
				REGION_NONE: rdata_r <= 8'h00;
				default: rdata_r <= 8'h00;
			endcase
		end
	end

	// Special registers come back from the core unregistered, in the same cycle that sfr_sel_o is high
	always_comb begin
		rdata_o = region_sfr_r ? sfr_rdata_i : rdata_r;
	end

	AST_RESET_VEC: assert property (@(posedge clk_sys_i)
		!rst_n_i |=> pc_o == `RESET_VECTOR)
		else $error("pc not zero after reset");

	AST_STATUS_RST: assert property (@(posedge clk_sys_i)
		!rst_n_i |=> status_o == `STATUS_RESET)
		else $error("status not at reset value");

	AST_IRQ_VEC: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		irq_take_i |=> pc_o == `IRQ_VECTOR)
		else $error("pc not at interrupt vector");

	AST_WRAP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		pc_load_i && !irq_take_i |=>
		{3'b000, prog_addr_o} == ($past(pc_load_val_i) & `PROG_IMPL_LAST))
		else $error("program address not wrapped");

	AST_PC_INC: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		pc_inc_i && !pc_load_i && !irq_take_i |=> pc_o == $past(pc_o) + 13'h0001)
		else $error("pc increment wrong");

	AST_UNIMP_ZERO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		req_i.valid && !req_i.wr && dec.region == REGION_NONE |=> rdata_o == 8'h00)
		else $error("unimplemented read not zero");

	AST_DIRECT_BANK: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		req_i.valid && !req_i.indirect && status_o[`BANK_BIT_POS] |=> sfr_addr_o[7])
		else $error("direct address bank bit wrong");

	AST_DIRECT_BANK0: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		req_i.valid && !req_i.indirect && !status_o[`BANK_BIT_POS] |=> !sfr_addr_o[7])
		else $error("direct address bank bit set in bank zero");

	AST_DIRECT_OP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		req_i.valid && !req_i.indirect |=> sfr_addr_o[6:0] == $past(req_i.operand))
		else $error("direct address operand wrong");

	AST_IND_ADDR: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		req_i.valid && req_i.indirect |=> sfr_addr_o == $past(req_i.pointer))
		else $error("indirect address wrong");

	AST_SFR_SEL: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		req_i.valid && dec.addr[6:0] <= `SFR_LAST |=> sfr_sel_o)
		else $error("special register not selected");

	AST_GPR_NOSFR: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		req_i.valid && dec.region == REGION_GPR |=> !sfr_sel_o)
		else $error("ram access selected special register");

	AST_RESERVED: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		status_wr_i |=> status_o[7:6] == 2'b00)
		else $error("reserved status bits set");

	AST_RVALID: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		req_i.valid && !req_i.wr |=> rvalid_o)
		else $error("read not answered");

	AST_NO_RVALID: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!(req_i.valid && !req_i.wr) |=> !rvalid_o)
		else $error("read valid without a read");
endmodule : memory_map_bank_decoder

// ### testbench/core_operand_model.sv
`timescale 1ns/10ps
module core_operand_model (
	input wire logic clk_sys_i,
	input wire logic sfr_sel_i,
	input wire logic [7:0] sfr_addr_i,
	output logic [7:0] sfr_rdata_o
);
	logic [7:0] idle_r = 8'h00;
	// Changing pattern while no special register is addressed
	always @(posedge clk_sys_i) begin
		idle_r <= idle_r + 8'h3B;
	end
	assign sfr_rdata_o = sfr_sel_i ? (sfr_addr_i ^ 8'h5A) : idle_r;
endmodule : core_operand_model

// ### testbench/memory_map_bank_decoder_tb.sv
`timescale 1ns/10ps
`include "mem_decode_map.svh"
module memory_map_bank_decoder_tb;
	import mem_decode_pkg::*;
	logic clk_sys_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic pc_load_i = 1'h0, pc_inc_i = 1'h0, irq_take_i = 1'h0, status_wr_i = 1'h0;
	logic [12:0] pc_load_val_i = 13'h0000;
	logic [7:0] status_wdata_i = 8'h00;
	data_req_t req_i = '0;
	logic [7:0] sfr_rdata_i, status_o, sfr_addr_o, rdata_o;
	logic [12:0] pc_o;
	logic [9:0] prog_addr_o;
	logic sfr_sel_o, rvalid_o, bank;
	logic [7:0] ram [64];
	logic [31:0] rnd = 32'h0000FA6B;
	int error_cnt = 0, samples_checked = 0, cyc = 0;
	always #25 clk_sys_i = ~clk_sys_i;
	memory_map_bank_decoder dut (.clk_sys_i, .rst_n_i, .pc_load_i, .pc_load_val_i, .pc_inc_i,
		.irq_take_i, .status_wr_i, .status_wdata_i, .req_i, .sfr_rdata_i, .pc_o, .prog_addr_o,
		.status_o, .sfr_sel_o, .sfr_addr_o, .rdata_o, .rvalid_o);
	core_operand_model core (.clk_sys_i, .sfr_sel_i(sfr_sel_o), .sfr_addr_i(sfr_addr_o),
		.sfr_rdata_o(sfr_rdata_i));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	function automatic logic [7:0] exp_data(input logic [7:0] a);
		if (a[6:0] < 7'h20) return a ^ 8'h5A;
		if (a[6:0] <= 7'h5F) return ram[6'(a[6:0] - 7'h20)];
		return 8'h00;
	endfunction : exp_data
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize();
		if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : summarize
	task automatic pcop(input logic [2:0] c, input logic [12:0] v, input logic [12:0] e);
		@(posedge clk_sys_i);
		{irq_take_i, pc_load_i, pc_inc_i} <= c;
		pc_load_val_i <= v;
		@(posedge clk_sys_i);
		{irq_take_i, pc_load_i, pc_inc_i} <= 3'h0;
		#1;
		check(pc_o, e);
		check(prog_addr_o, e[9:0]);
	endtask : pcop
	task automatic wstat(input logic [7:0] v);
		@(posedge clk_sys_i);
		status_wr_i <= 1'h1;
		status_wdata_i <= {2'h0, v[5:0]};
		@(posedge clk_sys_i);
		status_wr_i <= 1'h0;
		#1;
		bank = v[5];
		check(status_o, {2'h0, v[5:0]});
	endtask : wstat
	task automatic acc(input logic ind, input logic [6:0] op, input logic [7:0] ptr,
		input logic wr, input logic [7:0] wd);
		logic [7:0] a;
		a = ind ? ptr : {bank, op};
		@(posedge clk_sys_i);
		req_i <= '{1'h1, ind, op, ptr, wr, wd};
		@(posedge clk_sys_i);
		req_i.valid <= 1'h0;
		#1;
		check({sfr_sel_o, sfr_addr_o}, {a[6:0] < 7'h20, a});
		if (!wr) check({rvalid_o, rdata_o}, {1'h1, exp_data(a)});
		else check(rvalid_o, 1'h0);
		if (wr && a[6:0] >= 7'h20 && a[6:0] <= 7'h5F) ram[6'(a[6:0] - 7'h20)] = wd;
	endtask : acc
	initial begin
		bank = 1'h0;
		repeat (10) @(posedge clk_sys_i);
		rst_n_i <= 1'h1;
		#1;
		check(pc_o, 13'h0000);
		check(status_o, 8'h18);
		pcop(3'h2, 13'h03FF, 13'h03FF);
		pcop(3'h1, 13'h0000, 13'h0400);
		pcop(3'h2, 13'h1FFF, 13'h1FFF);
		pcop(3'h1, 13'h0000, 13'h0000);
		pcop(3'h7, 13'h0123, 13'h0004);
		pcop(3'h3, 13'h0ABC, 13'h0ABC);
		repeat (20) begin
			rnd = xs(rnd);
			pcop(3'h2, rnd[12:0], rnd[12:0]);
		end
		wstat(8'hFF);
		wstat(8'h00);
		for (int i = 0; i < 64; i++) begin
			rnd = xs(rnd);
			acc(1'h0, 7'(8'h20 + i), 8'h00, 1'h1, rnd[7:0]);
		end
		acc(1'h0, 7'h7F, 8'h00, 1'h0, 8'h00);
		acc(1'h1, 7'h00, 8'hA0, 1'h0, 8'h00);
		repeat (300) begin
			rnd = xs(rnd);
			if (rnd[31:28] == 4'h0) wstat(rnd[15:8]);
			else acc(rnd[0], rnd[7:1], rnd[15:8], rnd[16], rnd[24:17]);
		end
		// Second reset in mid-run, with pc and status away from their reset values
		wstat(8'h20);
		pcop(3'h2, 13'h1234, 13'h1234);
		@(posedge clk_sys_i);
		rst_n_i <= 1'h0;
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'h1;
		bank = 1'h0;
		#1;
		check(pc_o, `RESET_VECTOR);
		check(status_o, `STATUS_RESET);
		acc(1'h0, 7'h25, 8'h00, 1'h0, 8'h00);
		pcop(3'h1, 13'h0000, 13'h0001);
		summarize();
	end
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			summarize();
		end
	end
endmodule : memory_map_bank_decoder_tb
